// ===== hdl/icr_channel.sv
// One isolated data channel: edge and refresh encoder, bistable decoder, watchdog
`timescale 1ns/1ps
`default_nettype none
module icr_channel
    import icr_pkg::*;
#(
    parameter int REFRESH_CYC = ICR_REFRESH_CYC, // Cycles from one pulse to the next refresh pulse
    parameter int WD_CYC      = ICR_WATCHDOG_CYC // Silent cycles before default low
)
(
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic tx_enable_in,
    input  wire logic rx_enable_in,
    input  wire logic data_in,
    output logic      data_out,
    output logic      data_oe_out,
    output logic      set_pulse_out,
    output logic      clear_pulse_out
);

    // Counter wide enough for the watchdog span
    localparam int CNT_W = $clog2(WD_CYC + 2);

    // Watchdog must outlast the refresh period or a static input would flap
    generate
        if (REFRESH_CYC < 2 || WD_CYC <= REFRESH_CYC + 1 || ICR_PULSE_CYC != 1)
        begin : g_bad_timing
            $error("icr_channel: refresh or watchdog count out of range");
        end
    endgenerate

    logic             tx_armed;        // Sender was powered last cycle
    logic             tx_level;        // Level last encoded
    logic [CNT_W-1:0] tx_idle;         // Cycles since the last pulse sent
    logic [CNT_W-1:0] rx_quiet;        // Cycles since the last pulse seen
    logic             next_tx_armed;
    logic             next_tx_level;
    logic [CNT_W-1:0] next_tx_idle;
    logic [CNT_W-1:0] next_rx_quiet;
    logic             next_set;
    logic             next_clear;
    logic             next_data;
    logic             next_oe;

    // Encoder and decoder next state
    always_comb
    begin
        next_tx_armed = tx_enable_in;
        next_tx_level = tx_level;
        next_tx_idle  = tx_idle;
        next_set      = 1'b0;
        next_clear    = 1'b0;
        next_data     = data_out;
        next_oe       = data_oe_out;
        next_rx_quiet = rx_quiet;
        if (!tx_enable_in)
        begin
            // Sender in lockout: encoder idle, nothing crosses
            next_tx_level = 1'b0;
            next_tx_idle  = '0;
        end
        else if (!tx_armed || data_in != tx_level ||
                 tx_idle == CNT_W'(REFRESH_CYC - 1))
        begin
            // First sample after wake, an edge, or refresh of a static level
            next_set      = data_in;
            next_clear    = !data_in;
            next_tx_level = data_in;
            next_tx_idle  = '0;
        end
        else
        begin
            next_tx_idle = tx_idle + CNT_W'(1);
        end
        if (!rx_enable_in)
        begin
            // Receiver in lockout: released pin, decoder back to low
            next_data     = 1'b0;
            next_oe       = 1'b0;
            next_rx_quiet = '0;
        end
        else
        begin
            next_oe = 1'b1;
            if (set_pulse_out)
            begin
                next_data     = 1'b1;
                next_rx_quiet = '0;
            end
            else if (clear_pulse_out)
            begin
                next_data     = 1'b0;
                next_rx_quiet = '0;
            end
            else if (rx_quiet == CNT_W'(WD_CYC - 1))
            begin
                // Sender presumed dead; last level held until here
                next_data = 1'b0;
            end
            else
            begin
                next_rx_quiet = rx_quiet + CNT_W'(1);
            end
        end
    end

    // State registers
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tx_armed        <= 1'b0;
            tx_level        <= 1'b0;
            tx_idle         <= '0;
            rx_quiet        <= '0;
            set_pulse_out   <= 1'b0;
            clear_pulse_out <= 1'b0;
            data_out        <= 1'b0;
            data_oe_out     <= 1'b0;
        end
        else
        begin
            tx_armed        <= next_tx_armed;
            tx_level        <= next_tx_level;
            tx_idle         <= next_tx_idle;
            rx_quiet        <= next_rx_quiet;
            set_pulse_out   <= next_set;
            clear_pulse_out <= next_clear;
            data_out        <= next_data;
            data_oe_out     <= next_oe;
        end
    end

    // Checking helpers: gap between pulses sent, silence seen by the receiver
    logic [CNT_W-1:0] chk_gap;
    logic [CNT_W-1:0] chk_silent;
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            chk_gap    <= '0;
            chk_silent <= '0;
        end
        else
        begin
            chk_gap <= (!tx_enable_in || set_pulse_out || clear_pulse_out) ? '0 :
                       (chk_gap == '1) ? chk_gap : chk_gap + CNT_W'(1);
            chk_silent <= (!rx_enable_in || set_pulse_out || clear_pulse_out) ? '0 :
                          (chk_silent == '1) ? chk_silent : chk_silent + CNT_W'(1);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_pulse_narrow;
        (set_pulse_out || clear_pulse_out) |=> !(set_pulse_out && clear_pulse_out)
            && !($past(set_pulse_out) && set_pulse_out);
    endproperty
    a_pulse_narrow: assert property (p_pulse_narrow)
        else $error("edge pulse wider than one cycle");

    property p_edge_pulse;
        tx_enable_in && $past(tx_enable_in) && data_in != tx_level
            |=> (set_pulse_out == $past(data_in)) && (clear_pulse_out == !$past(data_in));
    endproperty
    a_edge_pulse: assert property (p_edge_pulse)
        else $error("input edge not encoded as a pulse");

    property p_decode;
        rx_enable_in && (set_pulse_out || clear_pulse_out)
            |=> data_out == $past(set_pulse_out);
    endproperty
    a_decode: assert property (p_decode)
        else $error("decoder did not follow the pulse");

    property p_refresh;
        tx_enable_in |-> chk_gap < CNT_W'(REFRESH_CYC);
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("refresh pulse late");

    property p_watchdog;
        chk_silent >= CNT_W'(WD_CYC) |-> !data_out;
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog did not force the default level");

    property p_lockout_hiz;
        !rx_enable_in |=> !data_oe_out && !data_out;
    endproperty
    a_lockout_hiz: assert property (p_lockout_hiz)
        else $error("output driven during lockout");

    property p_wake_send;
        $rose(tx_enable_in) |=> set_pulse_out || clear_pulse_out;
    endproperty
    a_wake_send: assert property (p_wake_send)
        else $error("no pulse after leaving lockout");

    c_refresh: cover property (tx_enable_in && chk_gap == CNT_W'(REFRESH_CYC - 1)
        ##1 set_pulse_out);
    c_watchdog: cover property (rx_enable_in && data_out ##1 !data_out && !clear_pulse_out
        && !$past(clear_pulse_out));

endmodule
`default_nettype wire

// ===== hdl/icr_top.sv
// Isolator top: channel arrays, supply lockout, converter control, thermal guard
`timescale 1ns/1ps
`default_nettype none
module icr_top
    import icr_pkg::*;
#(
    parameter int N_FWD       = ICR_FWD_CHANNELS,  // Primary-to-secondary channels
    parameter int N_REV       = ICR_REV_CHANNELS,  // Secondary-to-primary channels
    parameter int REFRESH_CYC = ICR_REFRESH_CYC,   // Refresh interval in cycles
    parameter int WD_CYC      = ICR_WATCHDOG_CYC,  // Watchdog timeout in cycles
    parameter int SETTLE_CYC  = ICR_SETTLE_CYC     // Settling delay in cycles
)
(
    input  wire logic                  clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  primary_supply_ok_in,
    input  wire logic                  iso_supply_ok_in,
    input  wire logic                  iso_setpoint_in,
    input  wire logic [ICR_TEMP_W-1:0] junction_temp_in,
    input  wire logic [N_FWD-1:0]      fwd_data_in,
    input  wire logic [N_REV-1:0]      rev_data_in,
    output logic      [N_FWD-1:0]      fwd_data_out,
    output logic      [N_FWD-1:0]      fwd_data_oe_out,
    output logic      [N_REV-1:0]      rev_data_out,
    output logic      [N_REV-1:0]      rev_data_oe_out,
    output logic                       osc_run_out,
    output logic                       pwm_drive_out,
    output logic                       full_power_out,
    output logic                       reg_ctrl_out,
    output logic                       thermal_shutdown_out,
    output logic                       link_valid_out
);

    // Width of the settle counter
    localparam int SET_W = $clog2(SETTLE_CYC + 2);

    // Refuse arrangements the channel logic cannot serve
    generate
        if (N_FWD < 1 || N_REV < 1 || N_FWD + N_REV > ICR_MAX_CHANNELS || SETTLE_CYC < 1)
        begin : g_bad_config
            $error("icr_top: channel split or settle count out of range");
        end
    endgenerate

    // Pulses crossing the barrier, one pair per channel
    logic [N_FWD-1:0]   fwd_set;        // Rise pulses toward the secondary
    logic [N_FWD-1:0]   fwd_clear;      // Fall pulses toward the secondary
    logic [N_REV-1:0]   rev_set;        // Rise pulses toward the primary
    logic [N_REV-1:0]   rev_clear;      // Fall pulses toward the primary

    // Converter and settle state
    icr_conv_state_type conv_state;     // Present converter mode
    icr_conv_state_type next_conv_state;
    logic [SET_W-1:0]   settle_cnt;     // Cycles both sides have been up
    logic [SET_W-1:0]   next_settle_cnt;
    logic               next_thermal;
    logic               next_reg_ctrl;
    logic               next_osc_run;
    logic               next_pwm_drive;
    logic               next_full_power;
    logic               next_link_valid;

    // Forward channels: primary encodes, secondary decodes
    genvar gi;
    generate
        for (gi = 0; gi < N_FWD; gi++)
        begin : g_fwd
            icr_channel #(
                .REFRESH_CYC (REFRESH_CYC),
                .WD_CYC      (WD_CYC)
            ) u_chan (
                .clk_in          (clk_in),
                .reset_n_in      (reset_n_in),
                .tx_enable_in    (primary_supply_ok_in),
                .rx_enable_in    (iso_supply_ok_in),
                .data_in         (fwd_data_in[gi]),
                .data_out        (fwd_data_out[gi]),
                .data_oe_out     (fwd_data_oe_out[gi]),
                .set_pulse_out   (fwd_set[gi]),
                .clear_pulse_out (fwd_clear[gi])
            );
        end
        // Reverse channels: secondary encodes, primary decodes
        for (gi = 0; gi < N_REV; gi++)
        begin : g_rev
            icr_channel #(
                .REFRESH_CYC (REFRESH_CYC),
                .WD_CYC      (WD_CYC)
            ) u_chan (
                .clk_in          (clk_in),
                .reset_n_in      (reset_n_in),
                .tx_enable_in    (iso_supply_ok_in),
                .rx_enable_in    (primary_supply_ok_in),
                .data_in         (rev_data_in[gi]),
                .data_out        (rev_data_out[gi]),
                .data_oe_out     (rev_data_oe_out[gi]),
                .set_pulse_out   (rev_set[gi]),
                .clear_pulse_out (rev_clear[gi])
            );
        end
    endgenerate

    // Converter mode, thermal hysteresis and link settling
    always_comb
    begin
        // Hysteresis: trip above the upper limit, release below the lower one
        if (thermal_shutdown_out)
        begin
            next_thermal = (junction_temp_in >= ICR_TEMP_RESTART_C);
        end
        else
        begin
            next_thermal = (junction_temp_in > ICR_TEMP_SHUTDOWN_C);
        end
        // Secondary only drives feedback while its own supply is out of lockout
        next_reg_ctrl = iso_supply_ok_in && iso_setpoint_in;
        // Mode priority: lockout, then thermal, then feedback
        if (!primary_supply_ok_in)
        begin
            next_conv_state = ICR_CONV_OFF;
        end
        else if (next_thermal)
        begin
            next_conv_state = ICR_CONV_THERMAL;
        end
        else if (reg_ctrl_out)
        begin
            next_conv_state = ICR_CONV_REGULATE;
        end
        else
        begin
            next_conv_state = ICR_CONV_FREE_RUN;
        end
        // Outputs decoded from the next mode so they stay flop-driven
        case (next_conv_state)
            ICR_CONV_OFF:
            begin
                next_osc_run    = 1'b0;
                next_pwm_drive  = 1'b0;
                next_full_power = 1'b0;
            end
            ICR_CONV_FREE_RUN:
            begin
                next_osc_run    = 1'b1;
                next_pwm_drive  = 1'b1;
                next_full_power = 1'b1;
            end
            ICR_CONV_REGULATE:
            begin
                next_osc_run    = 1'b1;
                next_pwm_drive  = 1'b1;
                next_full_power = 1'b0;
            end
            ICR_CONV_THERMAL:
            begin
                // Oscillator keeps running; only the drive is gated
                next_osc_run    = 1'b1;
                next_pwm_drive  = 1'b0;
                next_full_power = 1'b0;
            end
            default:
            begin
                next_osc_run    = 1'b0;
                next_pwm_drive  = 1'b0;
                next_full_power = 1'b0;
            end
        endcase
        // Link settling: data valid once both sides have been up long enough
        if (!(primary_supply_ok_in && iso_supply_ok_in))
        begin
            next_settle_cnt = '0;
            next_link_valid = 1'b0;
        end
        else if (settle_cnt == SET_W'(SETTLE_CYC - 1))
        begin
            next_settle_cnt = settle_cnt;
            next_link_valid = 1'b1;
        end
        else
        begin
            next_settle_cnt = settle_cnt + SET_W'(1);
            next_link_valid = link_valid_out;
        end
    end

    // Converter and settle registers
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            conv_state           <= ICR_CONV_OFF;
            settle_cnt           <= '0;
            thermal_shutdown_out <= 1'b0;
            reg_ctrl_out         <= 1'b0;
            osc_run_out          <= 1'b0;
            pwm_drive_out        <= 1'b0;
            full_power_out       <= 1'b0;
            link_valid_out       <= 1'b0;
        end
        else
        begin
            conv_state           <= next_conv_state;
            settle_cnt           <= next_settle_cnt;
            thermal_shutdown_out <= next_thermal;
            reg_ctrl_out         <= next_reg_ctrl;
            osc_run_out          <= next_osc_run;
            pwm_drive_out        <= next_pwm_drive;
            full_power_out       <= next_full_power;
            link_valid_out       <= next_link_valid;
        end
    end

    // Checking helper: cycles both supplies have been up, saturating
    logic [SET_W-1:0] chk_up;
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            chk_up <= '0;
        end
        else
        begin
            chk_up <= !(primary_supply_ok_in && iso_supply_ok_in) ? '0 :
                      (chk_up == SET_W'(SETTLE_CYC)) ? chk_up : chk_up + SET_W'(1);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_hot_stop;
        primary_supply_ok_in && junction_temp_in > ICR_TEMP_SHUTDOWN_C
            |=> thermal_shutdown_out && !pwm_drive_out && !full_power_out;
    endproperty
    a_hot_stop: assert property (p_hot_stop)
        else $error("drive not stopped above the shutdown limit");

    property p_hot_hold;
        thermal_shutdown_out && junction_temp_in >= ICR_TEMP_RESTART_C
            |=> thermal_shutdown_out;
    endproperty
    a_hot_hold: assert property (p_hot_hold)
        else $error("thermal shutdown released above the restart limit");

    property p_cool_resume;
        primary_supply_ok_in && thermal_shutdown_out
            && junction_temp_in < ICR_TEMP_RESTART_C |=> pwm_drive_out;
    endproperty
    a_cool_resume: assert property (p_cool_resume)
        else $error("drive not restored below the restart limit");

    property p_lockout_idle;
        !primary_supply_ok_in |=> !osc_run_out && fwd_set == '0 && fwd_clear == '0
            && rev_data_oe_out == '0;
    endproperty
    a_lockout_idle: assert property (p_lockout_idle)
        else $error("primary active during lockout");

    property p_iso_lockout;
        !iso_supply_ok_in |=> fwd_data_oe_out == '0 && rev_set == '0 && !reg_ctrl_out;
    endproperty
    a_iso_lockout: assert property (p_iso_lockout)
        else $error("secondary active during lockout");

    property p_free_run;
        primary_supply_ok_in && !reg_ctrl_out && !next_thermal |=> full_power_out;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("oscillator not free running without feedback");

    property p_regulate;
        iso_supply_ok_in && iso_setpoint_in && primary_supply_ok_in
            ##1 iso_supply_ok_in && iso_setpoint_in && primary_supply_ok_in
            && junction_temp_in < ICR_TEMP_RESTART_C
            |=> reg_ctrl_out && pwm_drive_out && !full_power_out;
    endproperty
    a_regulate: assert property (p_regulate)
        else $error("feedback did not modulate the drive");

    property p_settle;
        link_valid_out == (chk_up >= SET_W'(SETTLE_CYC));
    endproperty
    a_settle: assert property (p_settle)
        else $error("link valid at the wrong settle time");

    property p_wake_low;
        $rose(iso_supply_ok_in) |=> fwd_data_out == $past(fwd_set) && fwd_data_oe_out == '1;
    endproperty
    a_wake_low: assert property (p_wake_low)
        else $error("secondary outputs not initialised low");

    c_thermal_cycle: cover property ($rose(thermal_shutdown_out) ##[1:20]
        $fell(thermal_shutdown_out));
    c_regulate: cover property (full_power_out ##1 !full_power_out && pwm_drive_out);
    c_link_up: cover property ($rose(link_valid_out));

endmodule
`default_nettype wire

// ===== pkg/icr_pkg.sv
// Shared constants, timing conversions and types for the isolator channel model
`default_nettype none
package icr_pkg;

    // Reference clock rate, in kilohertz (25 MHz, 40 ns period)
    localparam int ICR_CLK_FREQ_KHZ = 25000;

    // Least time in ns to whole clock cycles, rounded up, never below one
    function automatic int icr_ceil_cyc(input int t_ns);
        int cyc;
        cyc = (t_ns * ICR_CLK_FREQ_KHZ + 999999) / 1000000;
        icr_ceil_cyc = (cyc < 1) ? 1 : cyc;
    endfunction

    // Longest time in ns to whole clock cycles, rounded down, never below one
    function automatic int icr_floor_cyc(input int t_ns);
        int cyc;
        cyc = (t_ns * ICR_CLK_FREQ_KHZ) / 1000000;
        icr_floor_cyc = (cyc < 1) ? 1 : cyc;
    endfunction

    // Times as printed, in ns
    localparam int ICR_PULSE_WIDTH_NS = 1;     // Width of an edge pulse
    localparam int ICR_REFRESH_TIME_NS = 1000; // Idle time before refresh pulses
    localparam int ICR_WATCHDOG_TIME_NS = 5000;// Silence before the output is forced
    localparam int ICR_SETTLE_TIME_NS = 1000;  // Outputs valid after activation

    // Derived cycle counts
    localparam int ICR_PULSE_CYC = icr_ceil_cyc(ICR_PULSE_WIDTH_NS);
    localparam int ICR_REFRESH_CYC = icr_ceil_cyc(ICR_REFRESH_TIME_NS);
    localparam int ICR_WATCHDOG_CYC = icr_ceil_cyc(ICR_WATCHDOG_TIME_NS);
    localparam int ICR_SETTLE_CYC = icr_floor_cyc(ICR_SETTLE_TIME_NS);

    // Channel arrangement: four channels split between the two directions
    localparam int ICR_MAX_CHANNELS = 4;
    localparam int ICR_FWD_CHANNELS = 2;
    localparam int ICR_REV_CHANNELS = 2;

    // Junction temperature thresholds in degrees Celsius
    localparam int ICR_TEMP_W = 8;
    localparam logic [7:0] ICR_TEMP_SHUTDOWN_C = 8'h96; // 150 C
    localparam logic [7:0] ICR_TEMP_RESTART_C = 8'h82;  // 130 C

    // Converter operating states
    typedef enum logic [1:0] {
        ICR_CONV_OFF      = 2'b00,
        ICR_CONV_FREE_RUN = 2'b01,
        ICR_CONV_REGULATE = 2'b10,
        ICR_CONV_THERMAL  = 2'b11
    } icr_conv_state_type;

endpackage
`default_nettype wire

// ===== sim/icr_far_logic.sv
// Far-side logic model: echoes received forward levels back on the reverse inputs
`timescale 1ns/1ps
`default_nettype none
module icr_far_logic
(
    input  wire logic       clk_in,
    input  wire logic [1:0] rx_data_in,
    input  wire logic [1:0] rx_oe_in,
    output logic      [1:0] tx_data_out
);
    initial tx_data_out = 2'h0;
    // A released line toggles every cycle, so a stale level can never pass as valid
    always @(posedge clk_in)
    begin
        tx_data_out <= (rx_data_in & rx_oe_in) | (~tx_data_out & ~rx_oe_in);
    end
endmodule
`default_nettype wire

// ===== sim/icr_top_tb.sv
// Self-checking bench for the isolator top, looped back through the far-side model
`timescale 1ns/1ps
`default_nettype none
module icr_top_tb;
    logic       clk_in     = 1'b0; // 25 MHz reference
    logic       reset_n_in = 1'b0; // Held low at start
    logic       pri_ok     = 1'b0; // Primary supply
    logic       iso_ok     = 1'b0; // Isolated supply
    logic       setpt      = 1'b0; // Isolated setpoint reached
    logic [7:0] temp       = 8'h19;
    logic [1:0] fwd_in     = 2'h0;
    logic [1:0] rev_in, fwd_out, fwd_oe, rev_out, rev_oe;
    logic       osc, pwm, full, regc, therm, lvalid;
    int         mismatches   = 0;
    int         total_checks = 0;
    always #20 clk_in = ~clk_in;
    // Short counts keep the run brief; expectations follow them
    icr_top #(.REFRESH_CYC(4), .WD_CYC(12), .SETTLE_CYC(4)) u_icr_top (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .primary_supply_ok_in(pri_ok),
        .iso_supply_ok_in(iso_ok), .iso_setpoint_in(setpt), .junction_temp_in(temp),
        .fwd_data_in(fwd_in), .rev_data_in(rev_in), .fwd_data_out(fwd_out),
        .fwd_data_oe_out(fwd_oe), .rev_data_out(rev_out), .rev_data_oe_out(rev_oe),
        .osc_run_out(osc), .pwm_drive_out(pwm), .full_power_out(full),
        .reg_ctrl_out(regc), .thermal_shutdown_out(therm), .link_valid_out(lvalid));
    icr_far_logic u_icr_far_logic (
        .clk_in(clk_in), .rx_data_in(fwd_out), .rx_oe_in(fwd_oe), .tx_data_out(rev_in));
    task automatic results();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    // Wait n edges, then look at the settled outputs mid-cycle
    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    // Bounded wait for channel 0 output; sel picks reverse instead of forward
    task automatic wt(input logic sel, input logic exp, input int lim, input string what);
        int i;
        for (i = 0; i < lim; i++)
        begin
            if ((sel ? rev_out[0] : fwd_out[0]) === exp)
                break;
            @(negedge clk_in);
        end
        chk(sel ? rev_out[0] : fwd_out[0], exp, what);
        if (i == lim)
            results();
    endtask
    task automatic t_power();
        chk(osc, 1'b0, "oscillator runs in lockout");
        chk(fwd_oe[0], 1'b0, "forward output driven in lockout");
        chk(rev_oe[0], 1'b0, "reverse output driven in lockout");
        @(posedge clk_in);
        pri_ok    <= 1'b1;
        fwd_in[0] <= 1'b1;
        settle(2);
        chk(osc, 1'b1, "oscillator idle");
        chk(full, 1'b1, "no free run");
        chk(rev_oe[0], 1'b1, "reverse output released");
        chk(rev_out[0], 1'b0, "reverse output not low");
        @(posedge clk_in);
        iso_ok <= 1'b1;
        settle(2);
        chk(lvalid, 1'b0, "link valid too early");
        wt(1'b0, 1'b1, 6, "forward output never follows");
        settle(4);
        chk(lvalid, 1'b1, "link valid missing");
        wt(1'b1, 1'b1, 8, "reverse output never follows");
        $display("t_power done");
    endtask
    task automatic t_conv();
        @(posedge clk_in);
        setpt <= 1'b1;
        settle(3);
        chk(regc, 1'b1, "no regulation signal");
        chk(full, 1'b0, "still full power");
        @(posedge clk_in);
        temp <= 8'h97;
        settle(2);
        chk(therm, 1'b1, "no thermal trip");
        chk(pwm, 1'b0, "drive on when hot");
        @(posedge clk_in);
        temp <= 8'h82;
        settle(3);
        chk(pwm, 1'b0, "drive back at restart level");
        @(posedge clk_in);
        temp <= 8'h81;
        settle(2);
        chk(pwm, 1'b1, "drive not restored");
        $display("t_conv done");
    endtask
    task automatic t_data();
        @(posedge clk_in);
        fwd_in <= 2'h2;
        settle(3);
        chk(fwd_out[0], 1'b0, "falling edge lost");
        chk(fwd_out[1], 1'b1, "second channel rise lost");
        @(posedge clk_in);
        fwd_in <= 2'h1;
        settle(3);
        chk(fwd_out[0], 1'b1, "rising edge lost");
        chk(fwd_out[1], 1'b0, "second channel fall lost");
        chk(rev_out[1], 1'b1, "second reverse channel lost");
        settle(30);
        chk(fwd_out[0], 1'b1, "static level dropped");
        chk(rev_out[0], 1'b1, "reverse static level dropped");
        chk(rev_out[1], 1'b0, "reverse fall lost");
        $display("t_data done");
    endtask
    task automatic t_down();
        @(posedge clk_in);
        pri_ok <= 1'b0;
        settle(2);
        chk(fwd_out[0], 1'b1, "last level not held");
        chk(osc, 1'b0, "oscillator not stopped");
        chk(rev_oe[0], 1'b0, "reverse output not released");
        wt(1'b0, 1'b0, 16, "watchdog never fires");
        @(posedge clk_in);
        iso_ok <= 1'b0;
        settle(2);
        chk(fwd_oe[0], 1'b0, "forward output not released");
        $display("t_down done");
    endtask
    initial
    begin
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        settle(2);
        t_power();
        t_conv();
        t_data();
        t_down();
        results();
    end
endmodule
`default_nettype wire
